// ==== tsop_defs.svh ====
/*
  Constants for the transport stream output port: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the port's source files.
*/
`ifndef TSOP_DEFS_SVH
`define TSOP_DEFS_SVH

// Register offsets (byte addresses)
`define TSOP_CTRL_OFS 8'h00
`define TSOP_STAT_OFS 8'h04
`define TSOP_PKT_OFS 8'h08

// Control field layout and reset value
`define TSOP_CTRL_W 6
`define TSOP_CTRL_RST 6'h00

// Status field positions
`define TSOP_ST_BUSY 0
`define TSOP_ST_REF 1
`define TSOP_ST_ERR 2
`define TSOP_ST_START 3

// Stream framing
`define TSOP_PKT_BYTES 188
`define TSOP_BITS_PER_BYTE 8

// Timing: system clock period in ns, byte clock half period and
// reference clock loss timeout, both in system clock cycles
`define TSOP_SYS_CLK_NS 20
`define TSOP_BYTE_HALF 2
`define TSOP_REF_TIMEOUT 64

`endif

// ==== tsop_pkg.sv ====
/*
  Types shared by the transport stream output port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package tsop_pkg;

  typedef enum logic [1:0] {
    TSOP_ST_IDLE,
    TSOP_ST_LOW,
    TSOP_ST_HIGH
  } tsop_state_t;

  // Bit 0 upward: enable, serial, then the four polarity inverts
  typedef struct packed {
    logic pol_err;
    logic pol_valid;
    logic pol_start;
    logic pol_clk;
    logic serial;
    logic enable;
  } tsop_ctrl_t;

  typedef struct packed {
    logic [7:0] data;
    logic err;
  } tsop_in_t;

  typedef struct packed {
    logic stream_byte_clock;
    logic packet_start_flag;
    logic packet_valid_qualifier;
    logic packet_error_flag;
    logic serial_stream_line;
    logic [7:0] parallel_stream_bus;
  } tsop_stream_t;

endpackage

`default_nettype wire

// ==== tsop_port.sv ====
/*
  Transport stream output port: takes bytes from the receiver core and
  drives the source-synchronous stream pins in parallel or serial mode.
  Assumes a 50 MHz sys_clk, a byte source with valid/ready handshake and
  a downstream demultiplexer sampling on the edge opposite the launch edge.
*/
// Design decisions made here: the plain strobed port and the address map.
// Behaviour
// - Four stream pin polarities independently configurable
// - All outputs change on one clock edge
// - Packet valid held active in data-only modes
// - Error flag held for whole errored packet
// - Packets are 188 bytes, start marks first
// - Serial start flag lasts eight byte-clock cycles
// - Parallel mode sends one byte per clock
// - Parallel byte clock 50 percent duty
// - Serial mode one bit per clock, 50 percent
// - Async active-low power-on reset, synchronised release
// - Reference clock 25 MHz or 4 MHz
`include "tsop_defs.svh"
`default_nettype none

module tsop_port
  import tsop_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = `TSOP_BYTE_HALF,
  parameter int unsigned PKT_BYTES = `TSOP_PKT_BYTES,
  parameter int unsigned REF_TIMEOUT = `TSOP_REF_TIMEOUT
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic power_on_reset_n,
  // Reference clock pin
  input wire logic reference_clock_input,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  // Byte source
  input wire tsop_in_t src_byte,
  input wire logic src_valid,
  output logic src_ready,
  // Stream pins
  output var tsop_stream_t stream_out
);

  localparam logic [7:0] LAST_POS = 8'(PKT_BYTES - 1);
  localparam logic [15:0] HALF_LAST = 16'(HALF_CYCLES - 1);
  localparam logic [15:0] REF_LIMIT = 16'(REF_TIMEOUT);
  localparam logic [3:0] BYTE_BITS = 4'(`TSOP_BITS_PER_BYTE);

  logic rst;
  tsop_ctrl_t ctrl_q;
  tsop_state_t state_q;
  logic [15:0] half_cnt_q;
  logic [2:0] bit_q;
  logic [7:0] pos_q;
  logic [7:0] shift_q;
  logic start_q;
  logic err_q;
  logic [15:0] pkt_cnt_q;
  logic [2:0] ref_sync_q;
  logic ref_level_q;
  logic [15:0] ref_idle_q;
  logic ref_alive_q;
  logic [31:0] rd_data_q;
  logic half_done;
  logic need_byte;
  logic at_launch;
  logic take;
  logic next_bit;
  logic launch;
  logic first_next;

  tsop_rst_sync u_rst_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .power_on_reset_n(power_on_reset_n),
    .rst_out(rst)
  );

  // Launch points: parked idle, or the end of the high phase
  assign half_done = (half_cnt_q == HALF_LAST);
  assign need_byte = !ctrl_q.serial || (bit_q == 3'h7);
  assign at_launch = (state_q == TSOP_ST_IDLE) || ((state_q == TSOP_ST_HIGH) && half_done);
  assign src_ready = ctrl_q.enable && need_byte && at_launch;
  assign take = src_ready && src_valid;
  assign next_bit = ctrl_q.enable && !need_byte && (state_q == TSOP_ST_HIGH) && half_done;
  assign launch = take || next_bit;
  assign first_next = (pos_q == LAST_POS);

  // Byte clock phase machine; the clock parks high when starved
  always_ff @(posedge sys_clk) begin
    if (rst || !ctrl_q.enable) begin
      state_q <= TSOP_ST_IDLE;
      half_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        TSOP_ST_IDLE: begin
          if (launch) begin
            state_q <= TSOP_ST_LOW;
            half_cnt_q <= 16'h0000;
          end
        end
        TSOP_ST_LOW: begin
          if (half_done) begin
            state_q <= TSOP_ST_HIGH;
            half_cnt_q <= 16'h0000;
          end else begin
            half_cnt_q <= half_cnt_q + 16'h0001;
          end
        end
        TSOP_ST_HIGH: begin
          if (half_done) begin
            state_q <= launch ? TSOP_ST_LOW : TSOP_ST_IDLE;
            half_cnt_q <= 16'h0000;
          end else begin
            half_cnt_q <= half_cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= TSOP_ST_IDLE;
          half_cnt_q <= 16'h0000;
        end
      endcase
    end
  end

  // Packet position; disabling realigns so the next byte starts a packet
  always_ff @(posedge sys_clk) begin
    if (rst || !ctrl_q.enable) begin
      pos_q <= LAST_POS;
      bit_q <= 3'h7;
    end else if (take) begin
      pos_q <= first_next ? 8'h00 : pos_q + 8'h01;
      bit_q <= 3'h0;
    end else if (next_bit) begin
      bit_q <= bit_q + 3'h1;
    end
  end

  // Byte and flag shadow, loaded on the launch edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_q <= 8'h00;
      start_q <= 1'b0;
      err_q <= 1'b0;
    end else if (!ctrl_q.enable) begin
      start_q <= 1'b0;
      err_q <= 1'b0;
    end else if (take) begin
      shift_q <= src_byte.data;
      start_q <= first_next;
      if (first_next) begin
        err_q <= src_byte.err;
      end
    end else if (next_bit) begin
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end

  // Pins follow the shadow by one cycle, all on the same sys_clk edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stream_out <= '0;
    end else begin
      stream_out.stream_byte_clock <= (state_q != TSOP_ST_LOW) ^ ctrl_q.pol_clk;
      stream_out.packet_start_flag <= start_q ^ ctrl_q.pol_start;
      stream_out.packet_valid_qualifier <= ctrl_q.enable ^ ctrl_q.pol_valid;
      stream_out.packet_error_flag <= err_q ^ ctrl_q.pol_err;
      stream_out.serial_stream_line <= ctrl_q.serial & shift_q[7];
      stream_out.parallel_stream_bus <= ctrl_q.serial ? 8'h00 : shift_q;
    end
  end

  // Reference clock watchdog; 25 MHz sampled at 50 MHz may alias, so
  // only presence is reported, never frequency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_sync_q <= 3'h0;
      ref_level_q <= 1'b0;
      ref_idle_q <= 16'h0000;
      ref_alive_q <= 1'b0;
    end else begin
      ref_sync_q <= {ref_sync_q[1:0], reference_clock_input};
      // A 25 MHz input flips on every sample and never settles, so
      // disagreement of the late stages counts as activity too
      if (ref_sync_q[1] != ref_sync_q[2]) begin
        ref_idle_q <= 16'h0000;
      end else if (ref_sync_q[2] != ref_level_q) begin
        ref_level_q <= ref_sync_q[2];
        ref_idle_q <= 16'h0000;
      end else if (ref_idle_q < REF_LIMIT) begin
        ref_idle_q <= ref_idle_q + 16'h0001;
      end
      ref_alive_q <= (ref_idle_q < REF_LIMIT);
    end
  end

  // Control register; mode and polarity steer the pins directly
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= tsop_ctrl_t'(`TSOP_CTRL_RST);
    end else if (reg_wr && (reg_addr == `TSOP_CTRL_OFS)) begin
      ctrl_q <= tsop_ctrl_t'(reg_wr_data[`TSOP_CTRL_W-1:0]);
    end
  end

  // Packet counter; a write to its offset clears it, and a new packet that same cycle leaves it at 1
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pkt_cnt_q <= 16'h0000;
    end else if (take && first_next) begin
      pkt_cnt_q <= (reg_wr && (reg_addr == `TSOP_PKT_OFS)) ? 16'h0001 : pkt_cnt_q + 16'h0001;
    end else if (reg_wr && (reg_addr == `TSOP_PKT_OFS)) begin
      pkt_cnt_q <= 16'h0000;
    end
  end

  // Read data stand from the cycle after the strobe for as long as the strobe is held
  always_ff @(posedge sys_clk) begin
    if (rst || !reg_rd) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `TSOP_CTRL_OFS: rd_data_q <= {26'h0, ctrl_q};
        `TSOP_STAT_OFS: begin
          rd_data_q <= 32'h0000_0000;
          rd_data_q[`TSOP_ST_BUSY] <= (state_q != TSOP_ST_IDLE);
          rd_data_q[`TSOP_ST_REF] <= ref_alive_q;
          rd_data_q[`TSOP_ST_ERR] <= err_q;
          rd_data_q[`TSOP_ST_START] <= start_q;
        end
        `TSOP_PKT_OFS: rd_data_q <= {16'h0, pkt_cnt_q};
        default: rd_data_q <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rd_data = rd_data_q;

  // Assertion helpers: cycles since last launch, bits under start
  logic [15:0] gap_q;
  logic [3:0] start_bits_q;

  always_ff @(posedge sys_clk) begin
    if (rst || launch) begin
      gap_q <= 16'h0000;
    end else if (gap_q != 16'hffff) begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_bits_q <= 4'h0;
    end else if (take) begin
      start_bits_q <= first_next ? 4'h1 : 4'h0;
    end else if (next_bit && start_q) begin
      start_bits_q <= start_bits_q + 4'h1;
    end
  end

  a_clock_period: assert property (
    @(posedge sys_clk) disable iff (rst)
    (launch && (state_q == TSOP_ST_HIGH)) |-> (gap_q == 16'(2 * HALF_CYCLES - 1)))
    else $error("byte clock period or duty wrong");

  a_data_on_fall: assert property (
    @(posedge sys_clk) disable iff (rst)
    $changed(shift_q) |-> ((state_q == TSOP_ST_LOW) && ($past(state_q) != TSOP_ST_LOW)))
    else $error("data changed away from the launch edge");

  a_valid_held: assert property (
    @(posedge sys_clk) disable iff (rst)
    ctrl_q.enable ##1 ctrl_q.enable |-> (stream_out.packet_valid_qualifier != $past(ctrl_q.pol_valid)))
    else $error("packet valid not held active");

  a_err_whole_pkt: assert property (
    @(posedge sys_clk) disable iff (rst)
    ($changed(err_q) && ctrl_q.enable && $past(ctrl_q.enable)) |-> (pos_q == 8'h00) && start_q)
    else $error("error flag changed inside a packet");

  a_pkt_wrap: assert property (
    @(posedge sys_clk) disable iff (rst)
    (take && (pos_q == LAST_POS)) |=> ((pos_q == 8'h00) && start_q))
    else $error("packet not 188 bytes");

  a_start_first: assert property (
    @(posedge sys_clk) disable iff (rst)
    start_q |-> (pos_q == 8'h00))
    else $error("start flag away from first byte");

  a_serial_start_len: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_q.serial && take && start_q) |-> (start_bits_q == BYTE_BITS))
    else $error("serial start flag not eight clocks");

  a_par_start_once: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!ctrl_q.serial && take && start_q) |=> !start_q)
    else $error("parallel start flag longer than one byte");

  a_par_byte_clock: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!ctrl_q.serial && launch) |-> take)
    else $error("parallel launch without a new byte");

endmodule

`default_nettype wire

// ==== tsop_port_bench.sv ====
/*
  Self-checking bench for the transport stream output port.
  Assumes the port, its package and the sink model are compiled first.
*/
`default_nettype none

module tsop_port_bench
  import tsop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 2;
  localparam int NB = 188;
  logic sys_clk = 1'b0, srst = 1'b1, por_n = 1'b0, ref_clk = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, src_valid = 1'b0, src_ready, chk_on = 1'b0;
  logic [7:0] reg_addr = 8'h00, rx_byte, lo_len;
  logic [31:0] reg_wr_data = 32'h0, reg_rd_data, d;
  logic [3:0] rx_start;
  logic got, rx_err, rx_valid, row_err = 1'b0;
  tsop_in_t src_byte = '0;
  tsop_stream_t so;
  tsop_ctrl_t cfg = '0;
  tsop_ctrl_t rows [4] = '{6'h01, 6'h3d, 6'h03, 6'h3f};
  logic row_errs [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int failures = 0, tests_run = 0, cyc = 0, tx_idx = 0, rx_idx = 0, n_send = 0, ref_half = 20;

  always #10 sys_clk = ~sys_clk;
  always #(ref_half) ref_clk = ~ref_clk;

  tsop_port #(.HALF_CYCLES(HALF), .PKT_BYTES(NB), .REF_TIMEOUT(64)) DUT (
    .sys_clk(sys_clk), .srst(srst), .power_on_reset_n(por_n), .reference_clock_input(ref_clk),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .src_byte(src_byte), .src_valid(src_valid), .src_ready(src_ready),
    .stream_out(so));
  tsop_sink u_sink (.sys_clk(sys_clk), .cfg(cfg), .pins(so), .got(got), .rx_byte(rx_byte),
    .rx_start(rx_start), .rx_err(rx_err), .rx_valid(rx_valid), .lo_len(lo_len));

  function automatic logic [7:0] pat(int i);
    return 8'(i * 7 + 3);
  endfunction

  task automatic final_report();
    $display("Counts: %0d compared, %0d failed", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] act, logic [31:0] exp, string what);
    tests_run++;
    if (act !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, what, act, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr_data <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rd_data;
  endtask

  task automatic start_feed(logic e);
    @(posedge sys_clk);
    tx_idx <= 0;
    n_send <= NB;
    src_byte <= '{data: pat(0), err: e};
    src_valid <= 1'b1;
  endtask

  // Error comes only with the first byte; the port must hold it alone
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      final_report();
    end else begin
      if (src_valid && src_ready) begin
        tx_idx <= tx_idx + 1;
        src_byte <= '{data: pat(tx_idx + 1), err: 1'b0};
        src_valid <= (tx_idx + 1 < n_send);
      end
      if (got === 1'b1 && chk_on) begin
        chk(rx_byte, pat(rx_idx), "byte");
        chk(rx_start, rx_idx == 0 ? (cfg.serial ? 8 : 1) : 0, "start length");
        chk(rx_err, row_err, "error flag");
        chk(rx_valid, 1, "valid");
        chk(lo_len, HALF, "low phase");
        rx_idx++;
      end
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    #1ms;
    por_n <= 1'b0;
    @(posedge sys_clk);
    por_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 chk(so, 13'h1000, "idle pins");
    rd(8'h00, d);
    chk(d, 0, "ctrl reset");
    wr(8'h0c, 32'h3f);
    rd(8'h0c, d);
    chk(d, 0, "unmapped");
    rd(8'h00, d);
    chk(d, 0, "ctrl after unmapped write");
    rd(8'h04, d);
    chk(d[1], 1, "ref alive 25");
    $display("Test reset done");
    for (int r = 0; r < 4; r++) begin
      // Polarities change only while disabled
      wr(8'h00, 32'(rows[r]) & 32'h3e);
      cfg <= rows[r] & 6'h3e;
      wr(8'h08, 32'h0);
      repeat (3) @(posedge sys_clk);
      cfg <= rows[r];
      row_err = row_errs[r];
      rx_idx = 0;
      chk_on = 1'b1;
      wr(8'h00, 32'(rows[r]));
      start_feed(row_errs[r]);
      repeat (NB * 16 * HALF + 200) if (rx_idx < NB) @(posedge sys_clk);
      chk(rx_idx, NB, "packet bytes");
      chk_on = 1'b0;
      rd(8'h08, d);
      chk(d, 1, "packet count");
      $display("Test row %0d done", r);
    end
    ref_half = 125;
    repeat (100) @(posedge sys_clk);
    rd(8'h04, d);
    chk(d[1], 1, "ref alive 4");
    $display("Test slow reference done");
    cfg <= '0;
    wr(8'h00, 32'h1);
    start_feed(1'b0);
    repeat (40) @(posedge sys_clk);
    #5 por_n = 1'b0;
    // Internal reset rises at once; the flops clear on the next edge
    @(posedge sys_clk);
    src_valid <= 1'b0;
    #1 chk(so, 0, "async reset pins");
    chk(src_ready, 0, "async reset ready");
    chk(reg_rd_data, 0, "async reset read data");
    repeat (3) @(posedge sys_clk);
    #5 por_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk(so, 0, "sync release");
    repeat (4) @(posedge sys_clk);
    #1 chk(so, 13'h1000, "idle after reset");
    rd(8'h00, d);
    chk(d, 0, "ctrl cleared");
    $display("Test power-on reset done");
    final_report();
  end
endmodule

`default_nettype wire

// ==== tsop_rst_sync.sv ====
/*
  Power-on reset synchroniser for the transport stream output port.
  Assumes an asynchronous active-low reset pin and a free-running sys_clk.
*/
`default_nettype none

module tsop_rst_sync (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic power_on_reset_n,
  // Combined internal reset
  output logic rst_out
);

  logic [2:0] sync_q;

  // Assertion is immediate, release waits for two clean stages
  always_ff @(posedge sys_clk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      sync_q <= 3'h7;
    end else begin
      sync_q <= {sync_q[1:0], 1'b0};
    end
  end

  assign rst_out = srst | sync_q[1] | sync_q[2];

  a_por_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    $rose(power_on_reset_n) |-> rst_out ##1 rst_out)
    else $error("internal reset released too early");

  a_por_assert: assert property (
    @(posedge sys_clk) disable iff (srst)
    !power_on_reset_n |-> rst_out)
    else $error("internal reset not active while pin low");

endmodule

`default_nettype wire

// ==== tsop_sink.sv ====
/*
  Downstream demultiplexer model for the transport stream output port.
  Assumes it sees the stream pins and the same polarity setting as the port.
*/
`default_nettype none

module tsop_sink
  import tsop_pkg::*;
(
  // Clock and pins
  input wire logic sys_clk,
  input wire tsop_ctrl_t cfg,
  input wire tsop_stream_t pins,
  // Captured bytes
  output logic got,
  output logic [7:0] rx_byte,
  output logic [3:0] rx_start,
  output logic rx_err,
  output logic rx_valid,
  output logic [7:0] lo_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_q, clk_s, st, er, va;
  logic [7:0] sh_q, lo_cnt;
  logic [3:0] bit_q, st_q;
  assign clk_s = pins.stream_byte_clock ^ cfg.pol_clk;
  assign st = pins.packet_start_flag ^ cfg.pol_start;
  assign er = pins.packet_error_flag ^ cfg.pol_err;
  assign va = pins.packet_valid_qualifier ^ cfg.pol_valid;
  // Samples on the edge opposite the launch edge
  always_ff @(posedge sys_clk) begin
    clk_q <= clk_s;
    got <= 1'b0;
    lo_cnt <= clk_s ? 8'h00 : lo_cnt + 8'h01;
    if (!cfg.enable) begin
      bit_q <= 4'h0;
      st_q <= 4'h0;
    end else if (clk_s && !clk_q) begin
      lo_len <= lo_cnt;
      rx_err <= er;
      rx_valid <= va;
      if (!cfg.serial) begin
        got <= 1'b1;
        rx_byte <= pins.parallel_stream_bus;
        rx_start <= {3'h0, st};
      end else begin
        sh_q <= {sh_q[6:0], pins.serial_stream_line};
        bit_q <= (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
        st_q <= (bit_q == 4'h7) ? 4'h0 : st_q + {3'h0, st};
        if (bit_q == 4'h7) begin
          got <= 1'b1;
          rx_byte <= {sh_q[6:0], pins.serial_stream_line};
          rx_start <= st_q + {3'h0, st};
        end
      end
    end
  end
endmodule

`default_nettype wire
